// *** rtl/printer_ctrl_status_upper.v ***
// upper half of the printer control and status register with indirect window
`timescale 1ns/1ps
`default_nettype none
`include "printer_ctrl_consts.vh"

module printer_ctrl_status_upper
(
	input  wire        core_clk,
	input  wire        rst,
	input  wire        bus_init,
	input  wire        master_reset,
	input  wire        reg_sel,
	input  wire        reg_write,
	input  wire [4:0]  reg_addr,
	input  wire [15:0] reg_wdata,
	output reg  [15:0] reg_rdata,
	input  wire [7:0]  lower_bits,
	input  wire        dma_done,
	input  wire        delivery_empty,
	input  wire        suffix_sent,
	input  wire        format_enabled,
	input  wire        dma_bus_request,
	input  wire        bus_grant,
	input  wire        master_strobe,
	input  wire        slave_ack_strobe,
	input  wire        cable_ground_ref,
	input  wire        vertical_forms_unit,
	input  wire        printer_offline,
	output reg         irq_request,
	output reg  [2:0]  indirect_ptr
);

	// timeout as a 14-bit figure, so compares need no padding
	localparam [13:0] TIMEOUT_LIMIT = `TIMEOUT_CYCLES;

	reg  [15:0] indirect_mem [0:7];
	reg         done;
	reg         dma_error;
	reg         offline_prev;
	reg  [1:0]  cable_sync;
	reg  [1:0]  forms_sync;
	reg  [1:0]  offline_sync;
	reg  [13:0] grant_cnt;
	reg  [13:0] ack_cnt;
	reg         next_done;
	reg         next_dma_error;
	reg  [2:0]  next_ptr;
	reg         next_irq;
	reg  [15:0] next_rdata;
	wire        soft_reset;
	wire        csr_hit;
	wire        win_hit;
	wire        csr_write;
	wire        win_write;
	wire        enable_write;
	wire        irq_enable;
	wire        cable_bit;
	wire        forms_bit;
	wire        offline_bit;
	wire        offline_rise;
	wire        grant_timeout;
	wire        ack_timeout;
	wire        transfer_finished;
	wire        set_error;
	wire        set_done;
	wire [13:0] next_grant_cnt;
	wire [13:0] next_ack_cnt;
	wire [15:0] csr_value;

	// saturating watchdog count, held at zero while idle
	function [13:0] count_up;
		input        run;
		input [13:0] cnt;
		begin
			if (!run)
				count_up = 14'h0000;
			else if (cnt == 14'h3fff)
				count_up = cnt;
			else
				count_up = cnt + 14'h0001;
		end
	endfunction

	// expiry lasts one cycle only, the count runs on past it
	function reached;
		input [13:0] cnt;
		begin
			reached = (cnt == TIMEOUT_LIMIT);
		end
	endfunction

	// address decode, shared by both register slots
	function hit;
		input       sel;
		input [4:0] addr;
		input [4:0] slot;
		begin
			hit = sel && (addr == slot);
		end
	endfunction

	// three-bit field wraps from seven back to zero on its own
	function [2:0] ptr_step;
		input [2:0] ptr;
		begin
			ptr_step = ptr + 3'h1;
		end
	endfunction

	// status word layout, upper half over the lower control byte
	function [15:0] pack_csr;
		input       err;
		input       offline;
		input       forms;
		input       cable;
		input [2:0] ptr;
		input       dn;
		input [6:0] low;
		begin
			pack_csr = {err, offline, forms, cable, 1'b0, ptr, dn, low};
		end
	endfunction

	assign soft_reset   = bus_init | master_reset;
	assign csr_hit      = hit(reg_sel, reg_addr, `CSR_OFFSET);
	assign win_hit      = hit(reg_sel, reg_addr, `DATA_WINDOW_OFFSET);
	assign csr_write    = csr_hit && reg_write;
	assign win_write    = win_hit && reg_write;
	assign enable_write = csr_write && reg_wdata[`BIT_PRINT_ENABLE];
	assign irq_enable   = lower_bits[`BIT_IRQ_ENABLE];

	// only the second flop of each synchroniser is read
	assign cable_bit    = cable_sync[1];
	assign forms_bit    = forms_sync[1];
	assign offline_bit  = offline_sync[1];
	// edge of the synchronised level, never of the raw pin
	assign offline_rise = offline_bit & ~offline_prev;

	assign next_ack_cnt   = count_up(master_strobe & ~slave_ack_strobe, ack_cnt);
	assign ack_timeout    = reached(ack_cnt);
	assign next_grant_cnt = count_up(dma_bus_request & ~bus_grant, grant_cnt);
	assign grant_timeout  = reached(grant_cnt);
	assign set_error      = (ack_timeout | grant_timeout) & ~dma_error;

	assign transfer_finished = dma_done && delivery_empty && (!format_enabled || suffix_sent);
	assign set_done = (transfer_finished | set_error) & ~done;

	assign csr_value = pack_csr(dma_error, offline_bit, forms_bit, cable_bit,
		indirect_ptr, done, lower_bits[6:0]);

	always @*
	begin
		next_rdata = 16'h0000;
		if (reg_sel)
		begin
			case (reg_addr)
				`CSR_OFFSET:
					next_rdata = csr_value;
				`DATA_WINDOW_OFFSET:
					next_rdata = indirect_mem[indirect_ptr];
				default:
					next_rdata = 16'h0000;
			endcase
		end
	end

	// set wins over a same-cycle clear by print enable
	always @*
	begin
		next_done      = done;
		next_dma_error = dma_error;
		if (soft_reset)
		begin
			next_done      = `DONE_RESET;
			next_dma_error = `ERROR_RESET;
		end
		else
		begin
			if (set_error)
				next_dma_error = 1'b1;
			else if (enable_write)
				next_dma_error = 1'b0;
			if (set_done)
				next_done = 1'b1;
			else if (enable_write)
				next_done = 1'b0;
		end
	end

	// clearing beats stepping, stepping beats a direct write
	always @*
	begin
		next_ptr = indirect_ptr;
		if (soft_reset)
			next_ptr = `PTR_RESET;
		else if (set_done || set_error)
			next_ptr = `PTR_RESET;
		else if (win_hit)
			next_ptr = ptr_step(indirect_ptr);
		else if (csr_write)
			next_ptr = reg_wdata[`FIELD_PTR_HI:`FIELD_PTR_LO];
	end

	// single-cycle request, masked by interrupt enable
	always @*
	begin
		next_irq = 1'b0;
		if (!soft_reset && irq_enable)
			next_irq = set_done || offline_rise;
	end

	// cable sense; reads unplugged until the pin is sampled
	always @(posedge core_clk or posedge rst)
	begin
		if (rst)
			cable_sync <= 2'b11;
		else
			cable_sync <= {cable_sync[0], cable_ground_ref};
	end

	// forms mirror, soft resets leave it alone
	always @(posedge core_clk or posedge rst)
	begin
		if (rst)
			forms_sync <= 2'b00;
		else
			forms_sync <= {forms_sync[0], vertical_forms_unit};
	end

	always @(posedge core_clk or posedge rst)
	begin
		if (rst)
			offline_sync <= 2'b00;
		else
			offline_sync <= {offline_sync[0], printer_offline};
	end

	always @(posedge core_clk or posedge rst)
	begin
		if (rst)
			grant_cnt <= 14'h0000;
		else
			grant_cnt <= next_grant_cnt;
	end

	always @(posedge core_clk or posedge rst)
	begin
		if (rst)
			ack_cnt <= 14'h0000;
		else
			ack_cnt <= next_ack_cnt;
	end

	always @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			done      <= `DONE_RESET;
			dma_error <= `ERROR_RESET;
		end
		else
		begin
			done      <= next_done;
			dma_error <= next_dma_error;
		end
	end

	always @(posedge core_clk or posedge rst)
	begin
		if (rst)
			indirect_ptr <= `PTR_RESET;
		else
			indirect_ptr <= next_ptr;
	end

	always @(posedge core_clk or posedge rst)
	begin
		if (rst)
			offline_prev <= 1'b0;
		else
			offline_prev <= offline_bit;
	end

	always @(posedge core_clk or posedge rst)
	begin
		if (rst)
			irq_request <= 1'b0;
		else
			irq_request <= next_irq;
	end

	// read data lags the select by one cycle and is zero otherwise
	always @(posedge core_clk or posedge rst)
	begin
		if (rst)
			reg_rdata <= 16'h0000;
		else
			reg_rdata <= next_rdata;
	end

	// indirect contents are indeterminate after reset, so no reset here
	always @(posedge core_clk)
	begin
		if (win_write)
			indirect_mem[indirect_ptr] <= reg_wdata;
	end

endmodule // printer_ctrl_status_upper
`default_nettype wire

// *** rtl/printer_ctrl_consts.vh ***
// constants for the printer control and status register, upper half
`ifndef PRINTER_CTRL_CONSTS_VH
`define PRINTER_CTRL_CONSTS_VH

`define CSR_OFFSET            5'h00
`define DATA_WINDOW_OFFSET    5'h10
`define BIT_PRINT_ENABLE      0
`define FIELD_FORMAT_LO       1
`define FIELD_FORMAT_HI       2
`define BIT_IRQ_ENABLE        6
`define BIT_DONE              7
`define FIELD_PTR_LO          8
`define FIELD_PTR_HI          10
`define BIT_UNUSED11          11
`define BIT_CABLE_SENSE       12
`define BIT_FORMS_READY       13
`define BIT_OFFLINE           14
`define BIT_DMA_ERROR         15
`define PTR_RESET             3'h0
`define DONE_RESET            1'h1
`define ERROR_RESET           1'h0
`define TIMEOUT_US            32
`define CLK_MHZ               200
`define TIMEOUT_CYCLES        (`TIMEOUT_US * `CLK_MHZ)

`endif

// *** testbench/printer_ctrl_props.sv ***
// assertions on the printer control status register ports
`timescale 1ns/1ps
`default_nettype none
module printer_ctrl_props (
	input wire logic core_clk, rst, bus_init, master_reset, reg_sel, reg_write,
	input wire logic dma_done, dma_bus_request, irq_request,
	input wire logic [4:0] reg_addr,
	input wire logic [15:0] reg_wdata, reg_rdata,
	input wire logic [7:0] lower_bits,
	input wire logic [2:0] indirect_ptr
);
	// pointer side effects of done or error would mask the step
	wire calm = !bus_init && !master_reset && !dma_done && !dma_bus_request;
	wire csr = reg_sel && reg_addr == 5'h00;
	wire win = reg_sel && reg_addr == 5'h10;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	property p_step; win && calm |=> indirect_ptr == $past(indirect_ptr) + 3'h1; endproperty
	a_step: assert property (p_step) else $error("ptr step");
	property p_init; bus_init || master_reset |=> indirect_ptr == 3'h0 && !irq_request; endproperty
	a_init: assert property (p_init) else $error("soft reset");
	property p_wr; csr && reg_write && calm |=> indirect_ptr == $past(reg_wdata[10:8]); endproperty
	a_wr: assert property (p_wr) else $error("ptr write");
	property p_b11; reg_rdata[11] == 1'b0; endproperty
	a_b11: assert property (p_b11) else $error("bit 11");
	property p_idle; !(csr || win) |=> reg_rdata == 16'h0000; endproperty
	a_idle: assert property (p_idle) else $error("idle data");
	property p_rd; csr && !reg_write |=> reg_rdata[10:8] == $past(indirect_ptr); endproperty
	a_rd: assert property (p_rd) else $error("ptr read");
	property p_en; irq_request |-> $past(lower_bits[6]); endproperty
	a_en: assert property (p_en) else $error("irq mask");
	property p_pulse; irq_request |=> !irq_request; endproperty
	a_pulse: assert property (p_pulse) else $error("irq pulse");
endmodule // printer_ctrl_props
bind printer_ctrl_status_upper printer_ctrl_props props (.core_clk, .rst, .bus_init,
	.master_reset, .reg_sel, .reg_write, .dma_done, .dma_bus_request, .irq_request,
	.reg_addr, .reg_wdata, .reg_rdata, .lower_bits, .indirect_ptr);
`default_nettype wire

// *** testbench/printer_model.sv ***
// printer side status lines
`timescale 1ns/1ps
`default_nettype none
module printer_model (
	input  wire logic [2:0] pins,
	output wire logic       cable_ground_ref, vertical_forms_unit, printer_offline
);
	assign {printer_offline, vertical_forms_unit, cable_ground_ref} = pins;
endmodule // printer_model
`default_nettype wire

// *** testbench/tb.sv ***
// self-checking bench for the printer control status register
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic core_clk = 0, rst = 1, bus_init = 0, master_reset = 0, reg_sel = 0, reg_write = 0;
	logic dma_done = 0, delivery_empty = 0, dma_bus_request = 0, tie = 0;
	logic fmt = 0, sfx = 0, mstb = 0;
	logic [4:0] reg_addr = 0;
	logic [15:0] reg_wdata = 0, q;
	logic [7:0] lower_bits = 0;
	logic [2:0] pins = 0;
	wire cable_ground_ref, vertical_forms_unit, printer_offline, irq_request;
	wire [15:0] reg_rdata;
	wire [2:0] indirect_ptr;
	int n_mismatch = 0, checks_done = 0;
	logic [25:0] rows [4] = '{{3'h0, 7'h00, 16'h0080}, {3'h1, 7'h15, 16'h1095},
		{3'h2, 7'h2a, 16'h20aa}, {3'h4, 7'h3f, 16'h40bf}};
	always #2.5 core_clk = ~core_clk;
	printer_ctrl_status_upper dut (.core_clk, .rst, .bus_init, .master_reset, .reg_sel,
		.reg_write, .reg_addr, .reg_wdata, .reg_rdata, .lower_bits, .dma_done, .delivery_empty,
		.suffix_sent(sfx), .format_enabled(fmt), .dma_bus_request, .bus_grant(tie),
		.master_strobe(mstb), .slave_ack_strobe(tie), .cable_ground_ref, .vertical_forms_unit,
		.printer_offline, .irq_request, .indirect_ptr);
	printer_model prn (.pins, .cable_ground_ref, .vertical_forms_unit, .printer_offline);
	task chk(input logic [15:0] got, exp);
		checks_done++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("mismatch %0t got %h want %h", $time, got, exp);
		end
	endtask
	task acc(input logic w, input logic [4:0] a, input logic [15:0] d);
		reg_sel <= 1;
		reg_write <= w;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_sel <= 0;
		#1 q = reg_rdata;
		@(posedge core_clk);
	endtask
	// pulse lasts one cycle, so poll every edge
	task wirq;
		for (int i = 0; i < 8 && irq_request !== 1'b1; i++) @(posedge core_clk);
		chk(irq_request, 1);
	endtask
	task finish_test;
		$display("mismatches %0d checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial
	begin
		repeat (2) @(posedge core_clk);
		rst <= 0;
		repeat (4) @(posedge core_clk);
		foreach (rows[i])
		begin
			pins <= rows[i][25:23];
			lower_bits <= {1'b0, rows[i][22:16]};
			repeat (4) @(posedge core_clk);
			acc(0, 5'h00, 0);
			chk(q, rows[i][15:0]);
		end
		pins <= 3'h0;
		lower_bits <= 8'h40;
		repeat (4) @(posedge core_clk);
		pins <= 3'h4;
		wirq;
		acc(1, 5'h00, 16'h0700);
		acc(0, 5'h10, 0);
		acc(1, 5'h10, 16'h1234);
		chk(indirect_ptr, 1);
		acc(0, 5'h07, 0);
		chk(q, 0);
		acc(1, 5'h00, 16'h0501);
		acc(0, 5'h00, 0);
		chk(q, 16'h4540);
		fmt <= 1;
		dma_done <= 1;
		delivery_empty <= 1;
		repeat (4) @(posedge core_clk);
		acc(0, 5'h00, 0);
		chk(q, 16'h4540);
		sfx <= 1;
		wirq;
		chk(indirect_ptr, 0);
		fmt <= 0;
		sfx <= 0;
		repeat (3) acc(0, 5'h10, 0);
		repeat (4) acc(1, 5'h10, 16'h0055);
		chk(indirect_ptr, 7);
		acc(1, 5'h00, 16'h0001);
		wirq;
		dma_done <= 0;
		acc(1, 5'h00, 16'h0001);
		dma_bus_request <= 1;
		pins <= 3'h6;
		repeat (6410) @(posedge core_clk);
		acc(0, 5'h00, 0);
		chk(q, 16'he0c0);
		dma_bus_request <= 0;
		bus_init <= 1;
		@(posedge core_clk);
		bus_init <= 0;
		acc(0, 5'h00, 0);
		chk(q, 16'h60c0);
		acc(1, 5'h00, 16'h0300);
		master_reset <= 1;
		@(posedge core_clk);
		master_reset <= 0;
		@(posedge core_clk);
		chk(indirect_ptr, 0);
		acc(1, 5'h00, 16'h0301);
		mstb <= 1;
		repeat (6410) @(posedge core_clk);
		acc(0, 5'h00, 0);
		chk(q, 16'he0c0);
		mstb <= 0;
		finish_test;
	end
	initial
	begin
		#150000;
		n_mismatch++;
		finish_test;
	end
endmodule // tb
`default_nettype wire
